/* File: src/nipc_pkg.sv */
// Package: constants and types of the nested interrupt priority controller
package nipc_pkg;

  // ----------------------------------------------------------------------
  // Register map (byte offsets of aligned 32-bit words)
  // ----------------------------------------------------------------------
  localparam logic [7:0] OFS_PRIO_0   = 8'h00;
  localparam logic [7:0] OFS_PRIO_1   = 8'h04;
  localparam logic [7:0] OFS_PRIO_2   = 8'h08;
  localparam logic [7:0] OFS_PRIO_3   = 8'h0c;
  localparam logic [7:0] OFS_EXT_CTRL = 8'h10;
  localparam logic [7:0] OFS_STATUS   = 8'h14;

  // ----------------------------------------------------------------------
  // Reset values and field layout
  // ----------------------------------------------------------------------
  localparam logic [7:0] PRIO_RST      = 8'hff;
  localparam logic [7:0] PRIO3_RO_MASK = 8'hf0;  // Upper nibble reads one
  localparam logic [7:0] EXT_CTRL_RST  = 8'h00;
  localparam logic [7:0] EXT_CTRL_MASK = 8'hfc;  // Bits 1:0 reserved
  localparam int         SENSE_B_POS   = 6;      // Groups 2 and 3
  localparam int         POL_B_POS     = 5;      // Group 2 inversion
  localparam int         SENSE_A_POS   = 3;      // Groups 0 and 1
  localparam int         POL_A_POS     = 2;      // Group 0 inversion
  localparam int         STAT_PEND_POS = 8;      // Pending vector bits

  // ----------------------------------------------------------------------
  // Priority codes (same encoding as the condition-code pair)
  // ----------------------------------------------------------------------
  localparam logic [1:0] PRIO_LVL0 = 2'b10;
  localparam logic [1:0] PRIO_LVL1 = 2'b01;
  localparam logic [1:0] PRIO_LVL2 = 2'b00;
  localparam logic [1:0] PRIO_LVL3 = 2'b11;

  // ----------------------------------------------------------------------
  // Vectors
  // ----------------------------------------------------------------------
  localparam int          NUM_VEC    = 14;
  localparam int          NUM_EXT    = 4;
  localparam int          EXT_VEC0   = 2;       // Group 0 is vector 2
  localparam int          SPI_VEC    = 8;
  localparam logic [15:0] VEC_RESET  = 16'hfffe;
  localparam logic [15:0] VEC_TRAP   = 16'hfffc;
  localparam logic [15:0] VEC_BASE   = 16'hfffa; // Vector 0, lower byte

  // Sensitivity codes
  localparam logic [1:0] SENSE_FALL_LOW = 2'b00;
  localparam logic [1:0] SENSE_RISE     = 2'b01;
  localparam logic [1:0] SENSE_FALL     = 2'b10;
  localparam logic [1:0] SENSE_BOTH     = 2'b11;

  // Core instruction codes affecting the current priority
  typedef enum logic [2:0] {
    OP_ENABLE_IRQ, OP_DISABLE_IRQ, OP_HALT, OP_WAIT_IRQ,
    OP_TRAP, OP_POP_CC, OP_IRQ_RETURN
  } nipc_op_t;

  // Halt state reported by the power sequencer
  typedef enum logic [1:0] {
    PM_RUN, PM_HALT, PM_ACTIVE_HALT, PM_AUTO_WAKEUP_HALT
  } nipc_pmode_t;

  // Instruction notice from the core
  typedef struct packed {
    logic       valid;
    nipc_op_t   op;
    logic [1:0] stacked_prio;  // Pair popped with the flags
  } nipc_instr_t;

  // Interrupt request towards the core
  typedef struct packed {
    logic        req;
    logic [3:0]  num;
    logic [15:0] addr;
  } nipc_irq_t;

endpackage

/* File: src/nipc_controller.sv */
// Module: nested interrupt priority controller with APB registers
// Functional notes
// - Priority registers reset to ff; upper nibble of the last reads one.
// - Two bits per vector 0..13, vector 0 in lowest bits of first register.
// - Stored pair uses the same coding as the current priority pair.
// - Writing the level-0 pattern to a field keeps that field unchanged.
// - Reset and trap have no programmable priority; servicing sets 11.
// - Raised priority of running pending vector re-enters; else next request.
// - Enable, halt and wait instructions load 10 into the current pair.
// - Disable instruction and trap load 11 into the current pair.
// - Pop of flags and interrupt return restore the stacked pair.
// - Masked flag supports jumps on pair equal 11 and not equal.
// - Priority instructions hold only until next return or such instruction.
// - Fixed order: reset, trap, vectors 0 to 13 lowest.
// - Halt wake only by reset, vectors 2..5, vector 8 in slave mode.
// - Vector 1 wakes active-halt only; vector 0 auto-wakeup halt only.
// - Four edge/level modes per group; rising-high only for groups 0, 2.
// - Sensitivity and polarity writable only while current pair is 11.
// - Changing any sensitivity or polarity field clears pending externals.
// - Bits 7:6 select group 2 sensitivity; bit 5 inverts first codes.
// - Bits 7:6 also set group 3 sensitivity without inversion.
// - External control register resets to zero.
// - Bit 5 inverts group 2, bit 2 inverts group 0.
// - Bits 4:3 select groups 0 and 1; inversion for group 0 only.
// - Request serviced only if enabled and above current; else pending.
// - Highest software priority first; ties go to hardware order.
//
// Chosen here: the register addresses and register access over APB.
`timescale 1ns/1ps

module nipc_controller #(
  parameter int ADDR_W = 8                      // APB address width
) (
  input  wire logic                 pclk,        // CPU clock, 250 MHz
  input  wire logic                 presetn,     // Async reset, active low
  input  wire logic                 psel,        // APB select
  input  wire logic                 penable,     // APB access phase
  input  wire logic                 pwrite,      // APB direction
  input  wire logic [ADDR_W-1:0]    paddr,       // APB byte address
  input  wire logic [31:0]          pwdata,      // APB write data
  output logic      [31:0]          prdata,      // APB read data
  output logic                      pready,      // APB ready
  output logic                      pslverr,     // APB error, unmapped
  input  wire logic [13:0]          periph_irq,  // Peripheral requests
  input  wire logic [3:0]           ext_pin,     // ORed pins per group
  input  wire logic                 spi_slave,   // SPI in slave mode
  input  wire nipc_pkg::nipc_pmode_t pmode,      // Current halt mode
  input  wire nipc_pkg::nipc_instr_t instr,      // Core instruction notice
  input  wire logic                 irq_ack,     // Core fetched vector
  output nipc_pkg::nipc_irq_t       irq,         // Request to core
  output logic [1:0]                cur_prio,    // Current priority pair
  output logic                      masked,      // Pair equals 11
  output logic                      wake         // Leave halt
);

  // ----------------------------------------------------------------------
  // Functions
  // ----------------------------------------------------------------------
  // Rank of a priority code, 0 lowest to 3 highest
  function automatic logic [1:0] prio_rank(input logic [1:0] code);
    case (code)
      nipc_pkg::PRIO_LVL0: prio_rank = 2'd0;
      nipc_pkg::PRIO_LVL1: prio_rank = 2'd1;
      nipc_pkg::PRIO_LVL2: prio_rank = 2'd2;
      default:             prio_rank = 2'd3;
    endcase
  endfunction

  // Field update that refuses the level-0 pattern
  function automatic logic [7:0] prio_merge(input logic [7:0] old_v,
                                            input logic [7:0] new_v);
    logic [7:0] res;
    res = old_v;
    for (int f = 0; f < 4; f++) begin
      if (new_v[2*f +: 2] != nipc_pkg::PRIO_LVL0) begin
        res[2*f +: 2] = new_v[2*f +: 2];
      end
    end
    prio_merge = res;
  endfunction

  // Pin event decode: bit 1 edge event, bit 0 level active
  function automatic logic [1:0] ext_detect(input logic [1:0] code,
                                            input logic       inv,
                                            input logic       now_v,
                                            input logic       prev_v);
    logic fall, rise, lvl;
    fall = inv ? (~prev_v & now_v) : (prev_v & ~now_v);
    rise = inv ? (prev_v & ~now_v) : (~prev_v & now_v);
    lvl  = inv ? now_v : ~now_v;
    case (code)
      nipc_pkg::SENSE_FALL_LOW: ext_detect = {fall, lvl};
      nipc_pkg::SENSE_RISE:     ext_detect = {rise, 1'b0};
      nipc_pkg::SENSE_FALL:     ext_detect = {fall, 1'b0};
      default:                  ext_detect = {fall | rise, 1'b0};
    endcase
  endfunction

  // Vectors able to end the given halt mode
  function automatic logic [13:0] wake_mask(
      input nipc_pkg::nipc_pmode_t m, input logic slave);
    logic [13:0] msk;
    msk = 14'h003c;
    msk[nipc_pkg::SPI_VEC] = slave;
    case (m)
      nipc_pkg::PM_ACTIVE_HALT:      msk[1] = 1'b1;
      nipc_pkg::PM_AUTO_WAKEUP_HALT: msk[0] = 1'b1;
      nipc_pkg::PM_HALT:             msk = msk;
      default:                       msk = 14'h3fff;
    endcase
    wake_mask = msk;
  endfunction

  // ----------------------------------------------------------------------
  // State
  // ----------------------------------------------------------------------
  logic [7:0]  prio_ff [4];
  logic [7:0]  ext_ctrl_ff;
  logic [1:0]  cur_prio_ff, nxt_cur_prio, best_rank;
  logic [3:0]  pin_s1_ff, pin_s2_ff, pin_prev_ff, ext_latch_ff;
  logic [31:0] prdata_ff, rd_val;
  logic        pready_ff, pslverr_ff, masked_ff, wake_ff;
  nipc_pkg::nipc_irq_t irq_ff;
  logic        apb_acc, apb_wr, addr_ok, ext_ctrl_wr, ext_ctrl_chg, best_found;
  logic [7:0]  nxt_ext_ctrl;
  logic [3:0]  ext_edge, ext_level, best_num;
  logic [13:0] pend, wmask;
  logic [27:0] vec_prio;

  // ----------------------------------------------------------------------
  // APB decode
  // ----------------------------------------------------------------------
  // One wait state so that read data comes from a flop
  assign apb_acc = psel & penable;
  assign apb_wr  = apb_acc & pready_ff & pwrite;

  always_comb begin
    addr_ok = 1'b1;
    rd_val  = 32'h0000_0000;
    case (paddr[7:0])
      nipc_pkg::OFS_PRIO_0:   rd_val[7:0] = prio_ff[0];
      nipc_pkg::OFS_PRIO_1:   rd_val[7:0] = prio_ff[1];
      nipc_pkg::OFS_PRIO_2:   rd_val[7:0] = prio_ff[2];
      nipc_pkg::OFS_PRIO_3:   rd_val[7:0] = prio_ff[3] |
                                            nipc_pkg::PRIO3_RO_MASK;
      nipc_pkg::OFS_EXT_CTRL: rd_val[7:0] = ext_ctrl_ff;
      nipc_pkg::OFS_STATUS: begin
        rd_val[1:0] = cur_prio_ff;
        rd_val[nipc_pkg::STAT_PEND_POS +: 14] = pend;
      end
      default:                addr_ok = 1'b0;
    endcase
    if (paddr[ADDR_W-1:0] > ADDR_W'(nipc_pkg::OFS_STATUS)) begin
      addr_ok = 1'b0;
      rd_val  = 32'h0000_0000;
    end
  end

  // Ready, error and read data for the access phase
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_ff  <= 1'b0;
      pslverr_ff <= 1'b0;
      prdata_ff  <= 32'h0000_0000;
    end else if (apb_acc && !pready_ff) begin
      pready_ff  <= 1'b1;
      pslverr_ff <= ~addr_ok;
      prdata_ff  <= pwrite ? 32'h0000_0000 : rd_val;
    end else begin
      pready_ff  <= 1'b0;
      pslverr_ff <= 1'b0;
    end
  end

  // ----------------------------------------------------------------------
  // Priority registers
  // ----------------------------------------------------------------------
  // A new field value only matters at the next arbitration, so a vector
  // already running keeps its entry level until it returns
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int r = 0; r < 4; r++) begin
        prio_ff[r] <= nipc_pkg::PRIO_RST;
      end
    end else if (apb_wr && addr_ok && paddr[7:4] == 4'h0) begin
      prio_ff[paddr[3:2]] <= prio_merge(prio_ff[paddr[3:2]],
                                        pwdata[7:0]);
    end
  end

  // Flat view: vector n uses bits 2n+1:2n
  always_comb begin
    for (int v = 0; v < nipc_pkg::NUM_VEC; v++) begin
      vec_prio[2*v +: 2] = prio_ff[v/4][2*(v%4) +: 2];
    end
  end

  // ----------------------------------------------------------------------
  // External interrupt control register
  // ----------------------------------------------------------------------
  assign nxt_ext_ctrl = pwdata[7:0] & nipc_pkg::EXT_CTRL_MASK;
  assign ext_ctrl_wr  = apb_wr && paddr[7:0] == nipc_pkg::OFS_EXT_CTRL &&
                        cur_prio_ff == nipc_pkg::PRIO_LVL3;
  assign ext_ctrl_chg = ext_ctrl_wr && nxt_ext_ctrl != ext_ctrl_ff;

  // Writes outside level 3 are dropped silently
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ext_ctrl_ff <= nipc_pkg::EXT_CTRL_RST;
    end else if (ext_ctrl_wr) begin
      ext_ctrl_ff <= nxt_ext_ctrl;
    end
  end

  // ----------------------------------------------------------------------
  // External pins
  // ----------------------------------------------------------------------
  // Two-stage synchroniser, then one more stage for edge history
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_s1_ff   <= 4'hf;
      pin_s2_ff   <= 4'hf;
      pin_prev_ff <= 4'hf;
    end else begin
      pin_s1_ff   <= ext_pin;
      pin_s2_ff   <= pin_s1_ff;
      pin_prev_ff <= pin_s2_ff;
    end
  end

  // Per-group sensitivity decode
  always_comb begin
    logic [1:0] d0, d1, d2, d3;
    d0 = ext_detect(ext_ctrl_ff[nipc_pkg::SENSE_A_POS +: 2],
                    ext_ctrl_ff[nipc_pkg::POL_A_POS],
                    pin_s2_ff[0], pin_prev_ff[0]);
    d1 = ext_detect(ext_ctrl_ff[nipc_pkg::SENSE_A_POS +: 2], 1'b0,
                    pin_s2_ff[1], pin_prev_ff[1]);
    d2 = ext_detect(ext_ctrl_ff[nipc_pkg::SENSE_B_POS +: 2],
                    ext_ctrl_ff[nipc_pkg::POL_B_POS],
                    pin_s2_ff[2], pin_prev_ff[2]);
    d3 = ext_detect(ext_ctrl_ff[nipc_pkg::SENSE_B_POS +: 2], 1'b0,
                    pin_s2_ff[3], pin_prev_ff[3]);
    ext_edge  = {d3[1], d2[1], d1[1], d0[1]};
    ext_level = {d3[0], d2[0], d1[0], d0[0]};
  end

  // Edge latches; a new edge beats a clear in the same cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ext_latch_ff <= 4'h0;
    end else begin
      for (int g = 0; g < nipc_pkg::NUM_EXT; g++) begin
        if (ext_edge[g]) begin
          ext_latch_ff[g] <= 1'b1;
        end else if (ext_ctrl_chg) begin
          ext_latch_ff[g] <= 1'b0;
        end else if (irq_ack && irq_ff.req &&
                     irq_ff.num == 4'(nipc_pkg::EXT_VEC0 + g)) begin
          ext_latch_ff[g] <= 1'b0;
        end
      end
    end
  end

  // ----------------------------------------------------------------------
  // Arbitration
  // ----------------------------------------------------------------------
  // Levels are not latched: an active level (low, or high when inverted) keeps requesting while it lasts
  always_comb begin
    pend = periph_irq;
    for (int g = 0; g < nipc_pkg::NUM_EXT; g++) begin
      pend[nipc_pkg::EXT_VEC0 + g] = ext_latch_ff[g] | ext_level[g];
    end
  end

  assign wmask = wake_mask(pmode, spi_slave);

  // Ascending scan with strict compare lets lower numbers win ties
  always_comb begin
    best_found = 1'b0;
    best_num   = 4'h0;
    best_rank  = 2'd0;
    for (int v = 0; v < nipc_pkg::NUM_VEC; v++) begin
      if (pend[v] && wmask[v] &&
          prio_rank(vec_prio[2*v +: 2]) > prio_rank(cur_prio_ff) &&
          (!best_found ||
           prio_rank(vec_prio[2*v +: 2]) > best_rank)) begin
        best_found = 1'b1;
        best_num   = 4'(v);
        best_rank  = prio_rank(vec_prio[2*v +: 2]);
      end
    end
  end

  // Request towards the core, dropped for a cycle after each fetch
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_ff <= '0;
    end else begin
      irq_ff.req  <= best_found && !(irq_ack && irq_ff.req);
      irq_ff.num  <= best_num;
      irq_ff.addr <= nipc_pkg::VEC_BASE -
                     16'({best_num, 1'b0});
    end
  end

  // ----------------------------------------------------------------------
  // Current priority pair
  // ----------------------------------------------------------------------
  // A fetch outranks a same-cycle instruction; reset leaves the pair at 11
  always_comb begin
    nxt_cur_prio = cur_prio_ff;
    if (irq_ack && irq_ff.req) begin
      nxt_cur_prio = vec_prio[2*irq_ff.num +: 2];
    end else if (instr.valid) begin
      case (instr.op)
        nipc_pkg::OP_ENABLE_IRQ, nipc_pkg::OP_HALT,
        nipc_pkg::OP_WAIT_IRQ:
          nxt_cur_prio = nipc_pkg::PRIO_LVL0;
        nipc_pkg::OP_DISABLE_IRQ, nipc_pkg::OP_TRAP:
          nxt_cur_prio = nipc_pkg::PRIO_LVL3;
        nipc_pkg::OP_POP_CC, nipc_pkg::OP_IRQ_RETURN:
          nxt_cur_prio = instr.stacked_prio;
        default:
          nxt_cur_prio = cur_prio_ff;
      endcase
    end
  end

  // Masked flag follows the same next value, so both change on one edge
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cur_prio_ff <= nipc_pkg::PRIO_LVL3;
      masked_ff   <= 1'b1;
    end else begin
      cur_prio_ff <= nxt_cur_prio;
      masked_ff   <= nxt_cur_prio == nipc_pkg::PRIO_LVL3;
    end
  end

  // ----------------------------------------------------------------------
  // Halt wake
  // ----------------------------------------------------------------------
  // Wake ignores the current pair; halt entry forces level 0 anyway
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wake_ff <= 1'b0;
    end else begin
      wake_ff <= (pmode != nipc_pkg::PM_RUN) && |(pend & wmask);
    end
  end

  // ----------------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------------
  assign prdata   = prdata_ff;
  assign pready   = pready_ff;
  assign pslverr  = pslverr_ff;
  assign irq      = irq_ff;
  assign cur_prio = cur_prio_ff;
  assign masked   = masked_ff;
  assign wake     = wake_ff;

endmodule // nipc_controller

/* File: testbench/nipc_props.sv */
// Checker of port behaviour for the priority controller
`timescale 1ns/1ps
module nipc_props (
  input wire logic                  pclk,     // Clock
  input wire logic                  presetn,  // Reset
  input wire logic                  psel,     // Select
  input wire logic                  penable,  // Access
  input wire logic                  pready,   // Ready
  input wire nipc_pkg::nipc_pmode_t pmode,    // Halt mode
  input wire nipc_pkg::nipc_instr_t instr,    // Notice
  input wire logic                  irq_ack,  // Fetch
  input wire nipc_pkg::nipc_irq_t   irq,      // Request
  input wire logic [1:0]            cur_prio, // Pair
  input wire logic                  masked,   // Pair 11
  input wire logic                  wake      // Wake
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // ----------------------------------------------
  // Instruction effects; a fetch in the same cycle wins
  // ----------------------------------------------
  logic ins, go10, go11, gopop;
  assign ins = instr.valid && !(irq_ack && irq.req);
  assign go10 = ins && (instr.op == nipc_pkg::OP_ENABLE_IRQ ||
    instr.op == nipc_pkg::OP_HALT || instr.op == nipc_pkg::OP_WAIT_IRQ);
  assign go11 = ins && (instr.op == nipc_pkg::OP_DISABLE_IRQ ||
    instr.op == nipc_pkg::OP_TRAP);
  assign gopop = ins && instr.op >= nipc_pkg::OP_POP_CC;
  sequence apb_setup; psel && !penable; endsequence
  sequence apb_first; psel && penable && !pready; endsequence
  AST_LOAD_10: assert property (go10 |=> cur_prio == 2'b10)
    else $error("pair not 10");
  AST_LOAD_11: assert property (
    go11 |=> masked && cur_prio == 2'b11)
    else $error("pair not 11");
  AST_RESTORE: assert property (
    gopop |=> cur_prio == $past(instr.stacked_prio))
    else $error("pair not restored");
  AST_MASKED: assert property (masked == (cur_prio == 2'b11))
    else $error("masked flag wrong");
  AST_ACK_DROP: assert property (irq_ack && irq.req |=> !irq.req)
    else $error("request held after fetch");
  AST_VEC_ADDR: assert property (
    irq.req |-> irq.addr == 16'hfffa - {11'h000, irq.num, 1'b0})
    else $error("vector address wrong");
  AST_RUN_NOWAKE: assert property (
    pmode == nipc_pkg::PM_RUN |=> !wake)
    else $error("wake while running");
  AST_ONE_WAIT: assert property (apb_setup ##1 apb_first |=> pready)
    else $error("ready late");
  AST_PULSE: assert property (pready |=> !pready)
    else $error("ready too long");
endmodule // nipc_props
bind nipc_controller nipc_props u_props (.pclk, .presetn, .psel, .penable,
  .pready, .pmode, .instr, .irq_ack, .irq, .cur_prio, .masked, .wake);

/* File: testbench/nipc_core_model.sv */
// Partner model: CPU core fetching vectors and issuing instructions
`timescale 1ns/1ps
module nipc_core_model (
  input  wire logic             pclk,    // Clock
  input  wire nipc_pkg::nipc_irq_t irq,  // Request
  output logic                  irq_ack, // Fetch
  output nipc_pkg::nipc_instr_t instr    // Notice
);
  int ack_dly = 0;  // A slow core waits this long before fetching
  initial begin
    irq_ack = 1'b0;
    instr = '0;
  end
  // Fetch; waits the full delay even if the request drops meanwhile
  always begin
    @(posedge pclk);
    if (irq.req === 1'b1) begin
      repeat (ack_dly) @(posedge pclk);
      irq_ack <= 1'b1;
      @(posedge pclk);
      irq_ack <= 1'b0;
    end
  end
  // One-cycle notice; the stacked pair matters to pop and return only
  task automatic exec(input nipc_pkg::nipc_op_t op, input logic [1:0] sp);
    @(posedge pclk);
    instr <= '{1'b1, op, sp};
    @(posedge pclk);
    instr <= '0;
  endtask
endmodule // nipc_core_model

/* File: testbench/nested_irq_priority_controller_bench.sv */
// Self-checking bench of the nested interrupt priority controller
`timescale 1ns/1ps
module nested_irq_priority_controller_bench;
  logic                  pclk, presetn, psel, penable, pwrite, pready;
  logic                  pslverr, spi_slave, irq_ack, masked, wake;
  logic [7:0]            paddr, v, prio [4];
  logic [31:0]           pwdata, prdata;
  logic [13:0]           periph_irq;
  logic [3:0]            ext_pin, vec_q [$];
  logic [1:0]            cur_prio;
  logic [32:0]           rd_q [$];
  nipc_pkg::nipc_pmode_t pmode;
  nipc_pkg::nipc_instr_t instr;
  nipc_pkg::nipc_irq_t   irq;
  int                    bad_count = 0, comparisons = 0, seed = 12;
  nipc_controller DUT (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .periph_irq, .ext_pin, .spi_slave,
    .pmode, .instr, .irq_ack, .irq, .cur_prio, .masked, .wake);
  nipc_core_model core (.pclk, .irq, .irq_ack, .instr);
  initial begin
    pclk = 1'b0;
    forever #2 pclk = ~pclk;
  end
  // Watchdog; the run needs well under a thousand cycles
  initial begin
    repeat (20000) @(posedge pclk);
    bad_count++;
    finish_test();
  end
  task automatic finish_test;
    $display("comparisons %0d mismatches %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  task automatic chk(input logic [32:0] got, input logic [32:0] exp);
    comparisons++;
    if (got !== exp) begin
      bad_count++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  // Monitor: each answer is matched with the oldest note
  always @(posedge pclk) begin
    if (psel && penable && pready === 1'b1 && !pwrite)
      chk({pslverr, prdata}, rd_q.pop_front());
    if (irq_ack === 1'b1 && irq.req === 1'b1)
      chk({29'h0, irq.num}, {29'h0, vec_q.pop_front()});
  end
  // APB master; holds the request until ready is sampled high
  task automatic apb(input logic wr, input logic [7:0] a, input logic [7:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= {24'h0, d};
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [32:0] e);
    rd_q.push_back(e);
    apb(1'b0, a, 8'h00);
  endtask
  // Level-0 pattern in a field keeps the old field
  function automatic logic [7:0] merge(input logic [7:0] o,
                                       input logic [7:0] n);
    for (int i = 0; i < 8; i += 2)
      if (n[i+:2] != nipc_pkg::PRIO_LVL0) o[i+:2] = n[i+:2];
    return o;
  endfunction
  initial begin
    {presetn, psel, penable, pwrite, spi_slave} = 5'h00;
    {paddr, pwdata, periph_irq} = '0;
    ext_pin = 4'hf;  // Pins idle high behind pull-ups
    pmode = nipc_pkg::PM_RUN;
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    for (int r = 0; r < 4; r++) begin
      prio[r] = nipc_pkg::PRIO_RST;
      rd(8'(r * 4), {25'h0, prio[r]});
    end
    rd(nipc_pkg::OFS_EXT_CTRL, 33'h0);
    rd(8'h18, {1'b1, 32'h0});
    repeat (6) for (int r = 0; r < 4; r++) begin
      v = 8'($random(seed));
      apb(1'b1, 8'(r * 4), v);
      prio[r] = merge(prio[r], v) | (r == 3 ? 8'hf0 : 8'h00);
      rd(8'(r * 4), {25'h0, prio[r]});
    end
    apb(1'b1, 8'h00, 8'hcf);
    apb(1'b1, 8'h00, 8'h64);
    rd(8'h00, {25'h0, 8'h44});
    $display("register test done");
    for (int k = 0; k < 7; k++)
      core.exec(nipc_pkg::nipc_op_t'(k), 2'b01);
    core.exec(nipc_pkg::OP_DISABLE_IRQ, 2'b00);
    // Control lands only while masked; the bench also writes it once while enabled
    v = (8'($random(seed)) & 8'hd8) | 8'h80;
    apb(1'b1, nipc_pkg::OFS_EXT_CTRL, v);
    rd(nipc_pkg::OFS_EXT_CTRL, {25'h0, v});
    core.exec(nipc_pkg::OP_ENABLE_IRQ, 2'b00);
    apb(1'b1, nipc_pkg::OFS_EXT_CTRL, ~v);
    rd(nipc_pkg::OFS_EXT_CTRL, {25'h0, v});
    core.exec(nipc_pkg::OP_DISABLE_IRQ, 2'b00);
    apb(1'b1, nipc_pkg::OFS_EXT_CTRL, 8'h00);
    $display("control test done");
    for (int r = 0; r < 3; r++)
      apb(1'b1, 8'(r * 4), 8'h55);
    apb(1'b1, 8'h0c, 8'h00);
    periph_irq <= 14'h1a00;
    repeat (4) @(posedge pclk);
    chk({32'h0, irq.req}, 33'h0);
    vec_q.push_back(4'd12);
    core.exec(nipc_pkg::OP_ENABLE_IRQ, 2'b00);
    repeat (8) @(posedge pclk);
    chk({31'h0, cur_prio}, {31'h0, nipc_pkg::PRIO_LVL2});
    chk({32'h0, irq.req}, 33'h0);
    periph_irq[12] <= 1'b0;
    core.ack_dly = 3;
    vec_q.push_back(4'd9);
    core.exec(nipc_pkg::OP_IRQ_RETURN, nipc_pkg::PRIO_LVL0);
    repeat (10) @(posedge pclk);
    periph_irq[9] <= 1'b0;
    vec_q.push_back(4'd11);
    core.exec(nipc_pkg::OP_IRQ_RETURN, nipc_pkg::PRIO_LVL0);
    repeat (10) @(posedge pclk);
    chk({32'h0, vec_q.size() == 0}, 33'h1);
    core.exec(nipc_pkg::OP_DISABLE_IRQ, 2'b00);
    $display("arbitration test done");
    pmode <= nipc_pkg::PM_HALT;
    periph_irq <= 14'h0200;
    repeat (4) @(posedge pclk);
    chk({32'h0, wake}, 33'h0);
    ext_pin[1] <= 1'b0;
    repeat (8) @(posedge pclk);
    chk({32'h0, wake}, 33'h1);
    // A differing control value drops the latched falling edge
    ext_pin[1] <= 1'b1;
    apb(1'b1, nipc_pkg::OFS_EXT_CTRL, 8'h10);
    repeat (2) @(posedge pclk);
    chk({32'h0, wake}, 33'h0);
    // Vector 0 wakes auto-wakeup halt (3) only, vector 1 active halt (2)
    // only, vector 8 every halt mode while the serial port is a slave
    spi_slave <= 1'b1;
    for (int m = 1; m < 4; m++) begin
      for (int b = 0; b < 3; b++) begin
        pmode <= nipc_pkg::nipc_pmode_t'(m);
        periph_irq <= 14'(1) << (b == 2 ? 8 : b);
        repeat (3) @(posedge pclk);
        chk({32'h0, wake}, {32'h0, b == 2 || b + m == 3});
      end
    end
    // Inverted group 0 turns the idle-high pin into a level request
    periph_irq <= '0;
    apb(1'b1, nipc_pkg::OFS_EXT_CTRL, 8'h04);
    repeat (2) @(posedge pclk);
    chk({32'h0, wake}, 33'h1);
    $display("wake test done");
    finish_test();
  end
endmodule // nested_irq_priority_controller_bench
